// ---- rtl/macrocell_array_init_ctrl.sv ----
// Product-term macrocell array with crossbar, configuration store and
// power-up / master reinitialisation sequencer.
// Assumes all pins arrive asynchronously to clk; APB master on clk.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "macrocell_defs.svh"

// Functional notes
// R1: Four blocks of 24 inputs, each from crossbar, fast pin or own feedback.
// R2: Each block's AND array makes 45 product terms for its nine macrocells.
// R3: Four of five terms are ORed, optionally inverted, into storage data.
// R4: Fifth term is an active-high async input, chosen as set or reset.
// R5: Storage is D, toggle, or transparent for a combinational output.
// R6: Each flip-flop clocks from one of two global fast clocks.
// R7: Pin enable from enable input A, B, always on or always off.
// R8: Macrocell outputs feed crossbar and own block while driving pins.
// R9: Outputs stay three-stated while configuration loads and registers initialise.
// R10: With master reset high, initialisation ends one interval after power-up.
// R11: Reset low at power-up: init runs, outputs wait for reset high.
// R12: Reset falling edge three-states outputs at once and restarts initialisation.
// R13: Early reset release still waits for the whole initialisation interval.
// R14: Each OR can take a neighbour's terms, four at a time; each block's first macrocell takes none.
// R15: Chaining nine macrocells gives one sum of up to 36 terms.
// R16: An exporting macrocell uses its set/reset term as register data.
// R17: Crossbar sources are macrocell outputs, two-way pins and fast inputs.
// R18: Crossbar gives 24 outputs per block, any source to any output.
// R19: Several sources on one crossbar output are ANDed together.
// R20: Security bits spread through the store block outside access.
// R21: Outside party holds master reset low at least 100 ns.
// R22: Register initial state selectable; unselected state is logic 1.
// R23: Initialisation interval is a parameter counted in clock cycles.
// R24: Master reset synchronised for sequencing; outputs disabled at once.
module macrocell_array_init_ctrl #(
  parameter logic [15:0] INIT_CYCLES = 16'(`INIT_CYCLES)
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire macrocell_pkg::apb_req_t   apb_req,
  output macrocell_pkg::apb_rsp_t        apb_rsp,
  input  wire logic                      global_fast_clock_a,
  input  wire logic                      global_fast_clock_b,
  input  wire logic                      master_reinit_n,
  input  wire logic                      pin_oe_a,
  input  wire logic                      pin_oe_b,
  input  wire logic [`FAST_PINS-1:0]     fast_in,
  input  wire logic [`NUM_MC-1:0]        io_in,
  output logic      [`NUM_MC-1:0]        io_out,
  output logic      [`NUM_MC-1:0]        io_oe_n
);
  import macrocell_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [`FAST_PINS-1:0] fast_s1, fast_s2;
  logic [`NUM_MC-1:0]    io_s1, io_s2;
  logic [2:0]            fca, fcb;
  logic                  mr_s1, mr_s2, mr_s3;
  logic                  oea_s1, oea_s2, oeb_s1, oeb_s2;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fast_s1 <= '0;
      fast_s2 <= '0;
      io_s1   <= '0;
      io_s2   <= '0;
      fca     <= 3'h0;
      fcb     <= 3'h0;
      oea_s1  <= 1'b0;
      oea_s2  <= 1'b0;
      oeb_s1  <= 1'b0;
      oeb_s2  <= 1'b0;
    end else begin
      fast_s1 <= fast_in;
      fast_s2 <= fast_s1;
      io_s1   <= io_in;
      io_s2   <= io_s1;
      fca     <= {fca[1:0], global_fast_clock_a};
      fcb     <= {fcb[1:0], global_fast_clock_b};
      oea_s1  <= pin_oe_a;
      oea_s2  <= oea_s1;
      oeb_s1  <= pin_oe_b;
      oeb_s2  <= oeb_s1;
    end
  end

  // Reset to low so a pin held low through power-up gives no falling edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mr_s1 <= 1'b0;
      mr_s2 <= 1'b0;
      mr_s3 <= 1'b0;
    end else begin
      mr_s1 <= master_reinit_n; // see R24
      mr_s2 <= mr_s1;
      mr_s3 <= mr_s2;
    end
  end

  logic mr_fall, fclk_a_rise, fclk_b_rise;
  assign mr_fall     = mr_s3 & ~mr_s2;
  assign fclk_a_rise = fca[1] & ~fca[2];
  assign fclk_b_rise = fcb[1] & ~fcb[2];

  // ==========================================================
  // APB slave, one wait state
  logic        access, nv_hit, nv_wr, locked, erase, soft_reinit;
  logic [9:0]  nv_idx;
  logic [31:0] nv_mem [`CFG_WORDS];
  logic [31:0] active [`CFG_WORDS];
  seq_state_t  state;

  assign access = apb_req.psel & apb_req.penable & apb_rsp.pready;
  assign nv_idx = apb_req.paddr[11:2];
  assign nv_hit = (apb_req.paddr[15:12] == `NV_PAGE) && (apb_req.paddr[1:0] == 2'h0)
                  && (nv_idx < 10'(`CFG_WORDS));
  assign locked = nv_mem[`SEC_BIT_A / 32][`SEC_BIT_A % 32]
                | nv_mem[`SEC_BIT_B / 32][`SEC_BIT_B % 32]
                | nv_mem[`SEC_BIT_C / 32][`SEC_BIT_C % 32]; // see R20
  assign nv_wr  = access & apb_req.pwrite & nv_hit & ~locked; // see R20
  assign erase  = access & apb_req.pwrite & (apb_req.paddr == `ADDR_CTRL)
                  & apb_req.pwdata[`CTRL_ERASE_BIT];
  assign soft_reinit = access & apb_req.pwrite & (apb_req.paddr == `ADDR_CTRL)
                       & apb_req.pwdata[`CTRL_REINIT_BIT];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      apb_rsp <= '0;
    end else if (apb_req.psel & apb_req.penable & ~apb_rsp.pready) begin
      apb_rsp.pready <= 1'b1;
      if (apb_req.paddr == `ADDR_CTRL) begin
        apb_rsp.prdata  <= 32'h0;
        apb_rsp.pslverr <= 1'b0;
      end else if (apb_req.paddr == `ADDR_STATUS) begin
        apb_rsp.prdata  <= {27'h0, mr_s2, locked, state[2], state[1], state[0]};
        apb_rsp.pslverr <= 1'b0;
      end else if (nv_hit & ~locked) begin
        apb_rsp.prdata  <= apb_req.pwrite ? 32'h0 : nv_mem[nv_idx];
        apb_rsp.pslverr <= 1'b0;
      end else begin
        // Locked store and unmapped space both answer with an error
        apb_rsp.prdata  <= 32'h0;
        apb_rsp.pslverr <= 1'b1;
      end
    end else begin
      apb_rsp <= '0;
    end
  end

  // Store keeps contents over reset; erase is the only way to unlock
  always_ff @(posedge clk) begin
    if (erase) begin
      for (int w = 0; w < `CFG_WORDS; w++) begin
        nv_mem[w] <= 32'h0;
      end
    end else if (nv_wr) begin
      nv_mem[nv_idx] <= apb_req.pwdata;
    end
  end

  // ==========================================================
  // Initialisation sequencer
  logic [15:0] init_cnt;
  logic [9:0]  ld_addr;
  logic        restart;

  assign restart = mr_fall | soft_reinit; // see R12

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= ST_INIT; // see R9
      init_cnt <= 16'h0;
    end else if (restart) begin
      state    <= ST_INIT; // see R12
      init_cnt <= 16'h0;
    end else begin
      unique case (state)
        ST_INIT: begin
          init_cnt <= init_cnt + 16'h1;
          if (init_cnt == INIT_CYCLES - 16'h1) begin // see R23
            state <= mr_s2 ? ST_RUN : ST_HOLD; // see R10, R13
          end
        end
        ST_HOLD: begin
          if (mr_s2) begin
            state <= ST_RUN; // see R11
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_INIT;
        end
      endcase
    end
  end

  // One word per cycle; the interval must exceed the image length
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ld_addr <= 10'h0;
      for (int w = 0; w < `CFG_WORDS; w++) begin
        active[w] <= 32'h0;
      end
    end else if (restart) begin
      ld_addr <= 10'h0;
    end else if (state == ST_INIT && ld_addr < 10'(`CFG_WORDS)) begin
      active[ld_addr] <= nv_mem[ld_addr]; // see R9
      ld_addr         <= ld_addr + 10'h1;
    end
  end

  logic [`CFG_BITS-1:0] cfg;
  for (genvar w = 0; w < `CFG_WORDS; w++) begin : g_flat
    assign cfg[32*w +: 32] = active[w];
  end

  // ==========================================================
  // Crossbar and block inputs
  // Feedback is taken from the pin register so no combinational loop forms
  logic [`XB_SRCS-1:0] xb_src;
  assign xb_src = {fast_s2, io_s2, io_out}; // see R17, R8

  logic [`BLK_INPUTS-1:0] blk_in [`NUM_BLOCKS];
  logic [`PT_PER_BLOCK-1:0] pt   [`NUM_BLOCKS];
  logic [`MC_PER_BLOCK-1:0] sum  [`NUM_BLOCKS];
  logic [`NUM_MC-1:0]       mc_val, mc_en;

  for (genvar b = 0; b < `NUM_BLOCKS; b++) begin : g_blk
    for (genvar k = 0; k < `BLK_INPUTS; k++) begin : g_in
      localparam int XB = `XB_BASE + (b * `BLK_INPUTS + k) * `XB_SRCS;
      localparam int BS = `BIS_BASE + (b * `BLK_INPUTS + k) * `BIS_STRIDE;
      logic       xo;
      logic [1:0] sel;
      logic [3:0] idx;
      // Unselected sources pass as 1, selected ones are ANDed
      assign xo  = &(xb_src | ~cfg[XB +: `XB_SRCS]); // see R18, R19
      assign sel = cfg[BS +: 2];
      assign idx = cfg[BS + 2 +: 4];
      always_comb begin
        unique case (sel) // see R1
          2'h0: blk_in[b][k] = xo;
          2'h1: blk_in[b][k] = (idx < 4'(`FAST_PINS)) ? fast_s2[idx] : 1'b0;
          2'h2: blk_in[b][k] = (idx < 4'(`MC_PER_BLOCK))
                               ? io_out[b * `MC_PER_BLOCK + idx] : 1'b0;
          2'h3: blk_in[b][k] = 1'b0;
        endcase
      end
    end

    for (genvar p = 0; p < `PT_PER_BLOCK; p++) begin : g_pt
      localparam int PB = `AND_BASE + (b * `PT_PER_BLOCK + p) * `PT_STRIDE;
      // True and complement literal masks
      assign pt[b][p] = &((blk_in[b] | ~cfg[PB +: 24])
                        & (~blk_in[b] | ~cfg[PB + 24 +: 24])); // see R2
    end

    // ==========================================================
    // Macrocells
    for (genvar m = 0; m < `MC_PER_BLOCK; m++) begin : g_mc
      localparam int I = b * `MC_PER_BLOCK + m;
      mc_cfg_t mc;
      logic    or4, d, sr, q, clk_edge;
      assign mc  = mc_cfg_t'(cfg[`MC_BASE + I * `MC_STRIDE +: 9]);
      assign or4 = |pt[b][m * `PT_PER_MC +: 4]; // see R3
      if (m == 0) begin : g_first
        assign sum[b][m] = or4;
      end else begin : g_chain
        // Previous macrocell's sum joins in groups of four
        assign sum[b][m] = or4 | (g_mc[m-1].mc.export_en & sum[b][m-1]); // see R14, R15
      end
      // Exporting cell reuses its fifth term as data and loses set/reset
      assign d  = mc.export_en ? pt[b][m * `PT_PER_MC + 4]
                               : (sum[b][m] ^ mc.invert); // see R16, R3
      assign sr = ~mc.export_en & pt[b][m * `PT_PER_MC + 4]; // see R4
      assign clk_edge = mc.clk_sel ? fclk_b_rise : fclk_a_rise; // see R6

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          q <= 1'b1;
        end else if (state != ST_RUN) begin
          q <= ~mc.init_zero; // see R22
        end else if (sr) begin
          q <= mc.sr_is_set; // see R4
        end else if (clk_edge) begin
          q <= (mc.mode == MODE_T) ? (q ^ d) : d; // see R5
        end
      end

      // Set/reset overrides the stored value while it is held
      assign mc_val[I] = (mc.mode == MODE_COMB) ? d : (sr ? mc.sr_is_set : q); // see R5, R4
      always_comb begin
        unique case (mc.oe_sel) // see R7
          OE_PIN_A: mc_en[I] = oea_s2;
          OE_PIN_B: mc_en[I] = oeb_s2;
          OE_ON:    mc_en[I] = 1'b1;
          OE_OFF:   mc_en[I] = 1'b0;
        endcase
      end
    end
  end

  // ==========================================================
  // Pin drivers
  logic [`NUM_MC-1:0] oe_off;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      io_out <= '1;
      oe_off <= '1;
    end else begin
      io_out <= mc_val; // see R8
      oe_off <= ~(mc_en & {`NUM_MC{state == ST_RUN & mr_s2}}); // see R9, R11, R13
    end
  end

  // Pin low must disable drivers before the synchroniser catches up
  assign io_oe_n = oe_off | {`NUM_MC{~master_reinit_n}}; // see R24, R12

endmodule : macrocell_array_init_ctrl
`default_nettype wire

// ---- rtl/macrocell_defs.svh ----
// Constants of the macrocell array: geometry, configuration bit layout,
// register offsets and sequencing counts.
// Assumes a 25 MHz system clock and an APB register bus with 16-bit address.
`ifndef MACROCELL_DEFS_SVH
`define MACROCELL_DEFS_SVH

// ==========================================================
// Geometry
`define NUM_BLOCKS        4
`define MC_PER_BLOCK      9
`define NUM_MC            36
`define BLK_INPUTS        24
`define PT_PER_BLOCK      45
`define PT_PER_MC         5
`define FAST_PINS         12
`define XB_SRCS           84
`define XB_SRC_IO         36
`define XB_SRC_FAST       72

// ==========================================================
// Configuration bit layout (flat bit index into the image)
`define PT_STRIDE         48
`define AND_BASE          0
`define XB_BASE           8640
`define BIS_BASE          16704
`define BIS_STRIDE        6
`define MC_BASE           17280
`define MC_STRIDE         16
`define SEC_BIT_A         17856
`define SEC_BIT_B         17900
`define SEC_BIT_C         17950
`define CFG_WORDS         561
`define CFG_BITS          17952

// ==========================================================
// Register map (byte addresses)
`define ADDR_CTRL         16'h0000
`define ADDR_STATUS       16'h0004
`define NV_PAGE           4'h1
`define CTRL_ERASE_BIT    0
`define CTRL_REINIT_BIT   1
`define STAT_INIT_BIT     0
`define STAT_HOLD_BIT     1
`define STAT_RUN_BIT      2
`define STAT_LOCK_BIT     3
`define STAT_MR_BIT       4

// ==========================================================
// Timing
`define CLK_PERIOD_NS     40
`define T_RESET_NS        160000
`define INIT_CYCLES       (`T_RESET_NS / `CLK_PERIOD_NS)

`endif

// ---- rtl/macrocell_pkg.sv ----
// Types shared by the macrocell array: bus carriers, macrocell options,
// sequencer states.
// Assumes macrocell_defs.svh is on the include path.
package macrocell_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef enum logic [1:0] {
    MODE_D    = 2'h0,
    MODE_T    = 2'h1,
    MODE_COMB = 2'h2,
    MODE_RSV  = 2'h3
  } store_mode_t;

  typedef enum logic [1:0] {
    OE_PIN_A = 2'h0,
    OE_PIN_B = 2'h1,
    OE_ON    = 2'h2,
    OE_OFF   = 2'h3
  } oe_sel_t;

  // Low bits of each macrocell's configuration slot
  typedef struct packed {
    logic        init_zero;
    logic        export_en;
    oe_sel_t     oe_sel;
    logic        clk_sel;
    logic        sr_is_set;
    store_mode_t mode;
    logic        invert;
  } mc_cfg_t;

  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN  = 3'b100
  } seq_state_t;

endpackage : macrocell_pkg

// ---- sim/macrocell_array_init_ctrl_asserts.sv ----
// Port checker for the macrocell array: APB timing and pin enables.
// Assumes it is bound onto the top module; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "macrocell_defs.svh"
module macrocell_array_init_ctrl_chk
  import macrocell_pkg::*;
#(
  parameter logic [15:0] INIT_CYCLES = 16'h0258
) (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire macrocell_pkg::apb_req_t apb_req,
  input wire macrocell_pkg::apb_rsp_t apb_rsp,
  input wire logic                   master_reinit_n,
  input wire logic [`NUM_MC-1:0]     io_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] since;
  logic        pin_q;
  logic        ctrl_restart;
  // ==========================================================
  // Cycles since reset, pin fall or restart command; leads the synchroniser.
  // Counting from the fall, not the release, so a long hold may enable at once.
  assign ctrl_restart = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
                        && apb_req.paddr == `ADDR_CTRL && apb_req.pwdata[`CTRL_REINIT_BIT];
  always_ff @(posedge clk) begin
    if (!rst_n) pin_q <= 1'b0;
    else pin_q <= master_reinit_n;
  end
  always_ff @(posedge clk) begin
    if (!rst_n || (pin_q && !master_reinit_n) || ctrl_restart) since <= 16'h0000;
    else if (since != 16'hffff) since <= since + 16'h0001;
  end
  // ==========================================================
  // First cycle after a command restart still shows the old enables
  a_init_quiet: assert property (since != 16'h0000 && since < INIT_CYCLES - 16'h0002
    |-> &io_oe_n)
    else $error("outputs enabled during initialisation");
  a_pin_low_off: assert property (!master_reinit_n |-> &io_oe_n)
    else $error("outputs enabled while master pin low");
  a_ready_wait: assert property ($rose(apb_req.penable) && apb_req.psel
    |-> !apb_rsp.pready ##1 apb_rsp.pready) else $error("ready not in second access cycle");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held too long");
  a_ready_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("ready outside access phase");
  a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("error without ready");
  a_idle_data: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
    else $error("read data outside answer");
  a_ctrl_zero: assert property (apb_rsp.pready && !apb_req.pwrite
    && apb_req.paddr == `ADDR_CTRL |-> apb_rsp.prdata == 32'h0) else $error("control read");
  a_unmapped_err: assert property (apb_rsp.pready && apb_req.paddr == 16'h0008
    |-> apb_rsp.pslverr) else $error("unmapped access accepted");
endmodule : macrocell_array_init_ctrl_chk
bind macrocell_array_init_ctrl macrocell_array_init_ctrl_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
  .clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .master_reinit_n(master_reinit_n), .io_oe_n(io_oe_n));
`default_nettype wire

// ---- sim/ext_logic_model.sv ----
// External system logic: master reset pin, fast clocks, board pull-ups.
// Assumes the bench calls pulse right after a rising clk edge.
`timescale 1ns/1ps
`default_nettype none
`include "macrocell_defs.svh"
module ext_logic_model (
  input  wire logic                 clk,
  input  wire logic [`NUM_MC-1:0]   io_out,
  input  wire logic [`NUM_MC-1:0]   io_oe_n,
  output logic                      master_reinit_n,
  output logic                      fclk_a,
  output logic                      fclk_b,
  output logic [`FAST_PINS-1:0]     fast_in,
  output logic [`NUM_MC-1:0]        io_in
);
  initial begin
    master_reinit_n = 1'b1;
    fclk_a = 1'b0;
    fclk_b = 1'b0;
    fast_in = 12'h000;
  end
  // ==========================================================
  // Released pins float to the pull-up, never the last value
  always_comb begin
    for (int i = 0; i < `NUM_MC; i++) io_in[i] = io_oe_n[i] ? 1'b1 : io_out[i];
  end
  task automatic pulse(input int n);
    int k;
    k = (n < 3) ? 3 : n;
    master_reinit_n <= 1'b0;
    repeat (k) @(posedge clk);
    master_reinit_n <= 1'b1;
  endtask : pulse
endmodule : ext_logic_model
`default_nettype wire

// ---- sim/macrocell_array_init_ctrl_tb.sv ----
// Self-checking bench: APB register traffic and reinitialisation.
// Assumes the design and checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "macrocell_defs.svh"
module macrocell_array_init_ctrl_tb;
  import macrocell_pkg::*;
  localparam int INIT = 600;
  logic clk = 1'b0, rst_n, pin_oe_a, pin_oe_b, mr_n, fa, fb, er;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  logic [`FAST_PINS-1:0] fast_in;
  logic [`NUM_MC-1:0]    io_in, io_out, io_oe_n;
  logic [31:0]           rd;
  int                    num_errors = 0, comparisons = 0;
  always #20 clk = ~clk;
  macrocell_array_init_ctrl #(.INIT_CYCLES(16'(INIT))) DUT (.clk(clk), .rst_n(rst_n),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .global_fast_clock_a(fa), .global_fast_clock_b(fb),
    .master_reinit_n(mr_n), .pin_oe_a(pin_oe_a), .pin_oe_b(pin_oe_b), .fast_in(fast_in),
    .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n));
  ext_logic_model mdl (.clk(clk), .io_out(io_out), .io_oe_n(io_oe_n), .master_reinit_n(mr_n),
    .fclk_a(fa), .fclk_b(fb), .fast_in(fast_in), .io_in(io_in));
  // ==========================================================
  task automatic close_out;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_pins(input logic [`NUM_MC-1:0] got, input logic [`NUM_MC-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t pins %h exp %h", $time, got, exp);
    end
  endtask : chk_pins
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      close_out();
    end
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge clk);
  endtask : apb
  // Pin low for hold cycles; enables return a whole interval after the fall, or soon after a later release
  task automatic reinit(input int hold);
    int rest;
    rest = INIT + 12 - hold;
    if (rest < 20) rest = 20;
    mdl.pulse(hold);
    chk_pins(io_oe_n, '1);
    repeat (rest - 20) @(posedge clk);
    chk_pins(io_oe_n, '1);
    repeat (20) @(posedge clk);
    chk_pins(io_oe_n, 36'h0);
  endtask : reinit
  // ==========================================================
  initial begin
    rst_n = 1'b0;
    apb_req = '0;
    pin_oe_a = 1'b0;
    pin_oe_b = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Fresh store is unknown: erase it before any configuration
    apb(1'b1, `ADDR_CTRL, 32'h1);
    // Set/reset terms of cells 0 and 1 made false by a literal and its complement
    apb(1'b1, 16'h1018, 32'h0100_0001);
    apb(1'b1, 16'h1034, 32'h0001_0000);
    apb(1'b1, 16'h1038, 32'h0000_0100);
    // Cell 0 always on; cell 1 on enable B and starts at zero
    apb(1'b1, 16'h1870, 32'h0120_0040);
    apb(1'b0, 16'h1870, 32'h0);
    chk(rd, 32'h0120_0040);
    apb(1'b1, `ADDR_CTRL, 32'h2);
    repeat (INIT - 10) @(posedge clk);
    chk_pins(io_oe_n, '1);
    repeat (20) @(posedge clk);
    chk_pins(io_oe_n, 36'hf_ffff_fffe);
    // Other cells sit in their always-true reset term
    chk_pins(io_out, 36'h0_0000_0001);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd, 32'h14);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 16'h0008, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b0, 16'h1002, 32'h0);
    chk({31'h0, er}, 32'h1);
    pin_oe_a <= 1'b1;
    repeat (6) @(posedge clk);
    chk_pins(io_oe_n, 36'h0_0000_0002);
    pin_oe_b <= 1'b1;
    repeat (6) @(posedge clk);
    chk_pins(io_oe_n, 36'h0);
    reinit(5);
    reinit(INIT + 50);
    // Security bit set, then reinit: store closed until erased
    apb(1'b1, 16'h18b8, 32'h1);
    apb(1'b1, `ADDR_CTRL, 32'h2);
    repeat (INIT + 10) @(posedge clk);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd, 32'h1c);
    apb(1'b0, 16'h1870, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, `ADDR_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    apb(1'b0, 16'h1870, 32'h0);
    chk({er, rd[30:0]}, 32'h0);
    close_out();
  end
endmodule : macrocell_array_init_ctrl_tb
`default_nettype wire
